// ==== rtl/asr_alarm_status.v ====
// Alarm status readback bank with product identifier and combined alarm.
`timescale 1ns/100ps
`include "asr_consts.vh"

// Function
// R1 - Product identifier is 24 bits over three byte registers, low byte lowest.
// R2 - Highest identifier register returns identifier bits 23 to 16.
// R3 - Summary register bit 0 returns the combined alarm; upper bits reserved.
// R4 - Reference loop near lock sets when lock count reaches limit over sixteen.
// R5 - Reference loop bit 6 shows acquiring, bit 5 shows locked.
// R6 - Bit 4 shows holdover; bits 3 to 0 show live input signal loss.
// R7 - Sync request bit sets when synthesis loop locked or disabled but unsynchronized.
// R8 - Dual lock bit is one only when both loops are locked.
// R9 - Phase status bit is one when output phase is stable.
// R10 - Never synchronized bit clears after any sync pulse or request.
// R11 - Synthesis loop near lock sets when its count reaches limit over sixteen.
// R12 - Latched bit 6 records synthesis loop acquisition since last clear.
// R13 - Latched bit 5 records reference loop acquisition since last clear.
// R14 - Latched bit 4 records reference loop holdover since last clear.
// R15 - Latched bits 3 to 0 record input signal loss since last clear.
// R16 - Reference loop sources reach the combined alarm only when masked in.
// R17 - Five general sources reach the combined alarm only when masked in.
// R18 - Combined alarm ORs enabled sources; records hold until external clear.
// R19 - Reserved bits and miscellaneous register read zero; writes have no effect.
module asr_alarm_status #(
  parameter [23:0] PART_ID = `ASR_PART_ID
) (
  input wire I_REF_CLK,
  input wire I_ARST_N,
  input wire I_RD_EN,
  input wire I_WR_EN,
  input wire [`ASR_ADDR_W-1:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire [`ASR_LOCK_CNT_W-1:0] I_REF_LOCK_COUNT,
  input wire [`ASR_LOCK_CNT_W-1:0] I_REF_LOCK_LIMIT,
  input wire I_REF_LOOP_ACQUIRING,
  input wire I_REF_LOOP_LOCKED,
  input wire I_REF_LOOP_IN_HOLDOVER,
  input wire [3:0] I_INPUT_SIGNAL_LOSS,
  input wire [`ASR_LOCK_CNT_W-1:0] I_SYNTH_LOCK_COUNT,
  input wire [`ASR_LOCK_CNT_W-1:0] I_SYNTH_LOCK_LIMIT,
  input wire I_SYNTH_LOOP_ACQUIRING,
  input wire I_SYNTH_LOOP_LOCKED,
  input wire I_SYNTH_LOOP_DISABLED,
  input wire I_OUTPUT_PHASE_STABLE,
  input wire I_SYNC_PULSE,
  input wire I_SYNC_REQUEST,
  input wire I_RECORD_CLEAR,
  input wire [7:0] I_REF_LOOP_MASK,
  input wire [4:0] I_GENERAL_MASK,
  output reg [7:0] O_RDATA,
  output reg O_RD_VALID,
  output reg O_ALARM
);

  ////////////////////////////////////////////////////////////////////////////
  // Near lock decode, shared by both loops.

  function near_lock;
    input [`ASR_LOCK_CNT_W-1:0] count;
    input [`ASR_LOCK_CNT_W-1:0] limit;
    begin
      near_lock = (count >= (limit >> `ASR_NEAR_SHIFT));
    end
  endfunction

  reg never_synchronized;
  reg [7:0] record;
  reg [7:0] next_rdata;

  wire rd_accept;
  wire sync_event;
  wire next_never_synchronized;
  wire ref_near;
  wire synth_near;
  wire synth_ready;
  wire sync_request_status;
  wire dual_locked;
  wire [7:0] ref_status;
  wire [7:0] general_status;
  wire [7:0] record_events;
  wire [7:0] next_record;

  wire [7:0] ref_masked;
  wire [4:0] general_masked;
  wire ref_alarm;
  wire general_alarm;
  wire next_alarm;
  wire [7:0] alarm_readback;
  wire [7:0] latched_readback;
  genvar g;

  ////////////////////////////////////////////////////////////////////////////
  // Identifier byte select, used by all three identifier registers.

  function [7:0] id_byte;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: id_byte = PART_ID[7:0];
        2'h1: id_byte = PART_ID[15:8];
        default: id_byte = PART_ID[23:16];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Access qualification; a read with the write strobe high is refused.

  assign rd_accept = I_RD_EN & ~I_WR_EN; // R19

  ////////////////////////////////////////////////////////////////////////////
  // Synchronization events, from the external pulse or a port request.

  assign sync_event = I_SYNC_PULSE | I_SYNC_REQUEST; // R10

  assign next_never_synchronized = never_synchronized & ~sync_event; // R10

  ////////////////////////////////////////////////////////////////////////////
  // Near lock flags of both loops.

  assign ref_near = near_lock(I_REF_LOCK_COUNT, I_REF_LOCK_LIMIT); // R4

  assign synth_near = near_lock(I_SYNTH_LOCK_COUNT, I_SYNTH_LOCK_LIMIT); // R11

  ////////////////////////////////////////////////////////////////////////////
  // Reference loop status word.

  assign ref_status[`ASR_BIT_NEAR] = ref_near; // R4

  assign ref_status[`ASR_BIT_ACQ] = I_REF_LOOP_ACQUIRING; // R5

  assign ref_status[`ASR_BIT_LOCK] = I_REF_LOOP_LOCKED; // R5

  assign ref_status[`ASR_BIT_HOLD] = I_REF_LOOP_IN_HOLDOVER; // R6

  assign ref_status[3:0] = I_INPUT_SIGNAL_LOSS; // R6

  ////////////////////////////////////////////////////////////////////////////
  // General status word.

  assign synth_ready = I_SYNTH_LOOP_LOCKED | I_SYNTH_LOOP_DISABLED; // R7

  assign sync_request_status = synth_ready & never_synchronized; // R7

  assign dual_locked = I_REF_LOOP_LOCKED & I_SYNTH_LOOP_LOCKED; // R8

  assign general_status[7:5] = 3'h0; // R19

  assign general_status[`ASR_BIT_SYNC_REQ] = sync_request_status; // R7

  assign general_status[`ASR_BIT_DUAL] = dual_locked; // R8

  assign general_status[`ASR_BIT_PHASE] = I_OUTPUT_PHASE_STABLE; // R9

  assign general_status[`ASR_BIT_NEVER_SYNC] = never_synchronized; // R10

  assign general_status[`ASR_BIT_SYNTH_NEAR] = synth_near; // R11

  ////////////////////////////////////////////////////////////////////////////
  // Events that set the sticky records.

  assign record_events[7] = 1'h0; // R19

  assign record_events[`ASR_BIT_SYNTH_ACQ_REC] = I_SYNTH_LOOP_ACQUIRING; // R12

  assign record_events[`ASR_BIT_REF_ACQ_REC] = I_REF_LOOP_ACQUIRING; // R13

  assign record_events[`ASR_BIT_HOLD_REC] = I_REF_LOOP_IN_HOLDOVER; // R14

  assign record_events[3:0] = I_INPUT_SIGNAL_LOSS; // R15

  ////////////////////////////////////////////////////////////////////////////
  // Sticky records; a new event in the clear cycle wins over the clear.

  generate
    for (g = 0; g < 8; g = g + 1) begin : g_rec
      assign next_record[g] = record_events[g] | (record[g] & ~I_RECORD_CLEAR); // R18
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Masked alarm sources, mask bits aligned with readback bits.

  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ref_mask
      assign ref_masked[g] = ref_status[g] & I_REF_LOOP_MASK[g]; // R16
    end

    for (g = 0; g < 5; g = g + 1) begin : g_gen_mask
      assign general_masked[g] = general_status[g] & I_GENERAL_MASK[g]; // R17
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Combined alarm.

  assign ref_alarm = |ref_masked; // R16

  assign general_alarm = |general_masked; // R17

  assign next_alarm = ref_alarm | general_alarm; // R18

  ////////////////////////////////////////////////////////////////////////////
  // Fixed readback words.

  assign alarm_readback = {7'h00, O_ALARM}; // R3

  assign latched_readback = {1'h0, record[6:0]}; // R19

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; writes are ignored entirely.

  always @* begin
    next_rdata = 8'h00;
    case (I_ADDR)
      `ASR_ADDR_ID_LOW: begin
        next_rdata = id_byte(2'h0); // R1
      end
      `ASR_ADDR_ID_MID: begin
        next_rdata = id_byte(2'h1); // R1
      end
      `ASR_ADDR_ID_HIGH: begin
        next_rdata = id_byte(2'h2); // R2
      end
      `ASR_ADDR_ALARM: begin
        next_rdata = alarm_readback; // R3
      end
      `ASR_ADDR_REF_LOOP: begin
        next_rdata = ref_status; // R4
      end
      `ASR_ADDR_GENERAL: begin
        next_rdata = general_status; // R7
      end
      `ASR_ADDR_LATCHED: begin
        next_rdata = latched_readback; // R12
      end
      `ASR_ADDR_MISC: begin
        next_rdata = 8'h00; // R19
      end
      default: begin
        next_rdata = 8'h00; // R19
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  ////////////////////////////////////////////////////////////////////////////
  // Sync history.

  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      never_synchronized <= 1'h1;
    end else begin
      never_synchronized <= next_never_synchronized; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky record storage.

  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      record <= 8'h00;
    end else begin
      record <= next_record; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combined alarm output.

  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_ALARM <= 1'h0;
    end else begin
      O_ALARM <= next_alarm; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read valid strobe.

  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RD_VALID <= 1'h0;
    end else begin
      O_RD_VALID <= rd_accept; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, held until the next accepted read.

  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= 8'h00;
    end else begin
      if (rd_accept) begin
        O_RDATA <= next_rdata; // R19
      end
    end
  end

endmodule // asr_alarm_status

// ==== rtl/asr_consts.vh ====
// Constants for the alarm status readback bank.
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
`define ASR_ADDR_W 16
`define ASR_ADDR_ID_LOW 16'h0078
`define ASR_ADDR_ID_MID 16'h0079
`define ASR_ADDR_ID_HIGH 16'h007A
`define ASR_ADDR_ALARM 16'h007B
`define ASR_ADDR_REF_LOOP 16'h007C
`define ASR_ADDR_GENERAL 16'h007D
`define ASR_ADDR_LATCHED 16'h007E
`define ASR_ADDR_MISC 16'h007F
`define ASR_PART_ID 24'h5A5A01
`define ASR_LOCK_CNT_W 16
`define ASR_NEAR_SHIFT 4
`define ASR_BIT_NEAR 7
`define ASR_BIT_ACQ 6
`define ASR_BIT_LOCK 5
`define ASR_BIT_HOLD 4
`define ASR_BIT_SYNC_REQ 4
`define ASR_BIT_DUAL 3
`define ASR_BIT_PHASE 2
`define ASR_BIT_NEVER_SYNC 1
`define ASR_BIT_SYNTH_NEAR 0
`define ASR_BIT_SYNTH_ACQ_REC 6
`define ASR_BIT_REF_ACQ_REC 5
`define ASR_BIT_HOLD_REC 4
`endif

// ==== sim/asr_alarm_status_asserts.sv ====
// Concurrent checks on the alarm status readback bank.
`timescale 1ns/100ps
module asr_alarm_status_asserts #(parameter [23:0] PART_ID = 24'h000000) (
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic I_RD_EN,
  input wire logic I_WR_EN,
  input wire logic I_REF_LOOP_LOCKED,
  input wire logic I_SYNTH_LOOP_LOCKED,
  input wire logic I_OUTPUT_PHASE_STABLE,
  input wire logic O_RD_VALID,
  input wire logic O_ALARM,
  input wire logic [15:0] I_ADDR,
  input wire logic [3:0] I_INPUT_SIGNAL_LOSS,
  input wire logic [7:0] I_REF_LOOP_MASK,
  input wire logic [7:0] O_RDATA,
  input wire logic [4:0] I_GENERAL_MASK
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);
  wire logic rd = I_RD_EN & ~I_WR_EN;
  a_read_answered: assert property (rd |=> O_RD_VALID) else $error("read lost");
  a_write_refused: assert property (I_WR_EN |=> !O_RD_VALID) else $error("write read");
  a_id_low: assert property (rd && I_ADDR == 16'h0078 |=> O_RDATA == PART_ID[7:0])
    else $error("id low wrong");
  a_id_high: assert property (rd && I_ADDR == 16'h007A |=> O_RDATA == PART_ID[23:16])
    else $error("id high wrong");
  a_loss_live: assert property (rd && I_ADDR == 16'h007C
    |=> O_RDATA[3:0] == $past(I_INPUT_SIGNAL_LOSS)) else $error("loss bits wrong");
  a_lock_phase: assert property (rd && I_ADDR == 16'h007D |=> O_RDATA[3:2] ==
    {$past(I_REF_LOOP_LOCKED) & $past(I_SYNTH_LOOP_LOCKED), $past(I_OUTPUT_PHASE_STABLE)})
    else $error("lock or phase bit wrong");
  a_misc_zero: assert property (rd && I_ADDR == 16'h007F |=> O_RDATA == 8'h00)
    else $error("misc not zero");
  a_alarm_off: assert property (I_REF_LOOP_MASK == 8'h00 && I_GENERAL_MASK == 5'h00
    |=> !O_ALARM) else $error("alarm while masked");
  a_alarm_loss: assert property (|(I_INPUT_SIGNAL_LOSS & I_REF_LOOP_MASK[3:0])
    |=> O_ALARM) else $error("alarm missing");
endmodule // asr_alarm_status_asserts
bind asr_alarm_status asr_alarm_status_asserts #(.PART_ID(PART_ID)) chk_u(.*);

// ==== sim/asr_alarm_status_tb.sv ====
// Self-checking testbench for the alarm status readback bank.
`timescale 1ns/100ps
module asr_alarm_status_tb;
  localparam [23:0] ID = 24'hC3A512; // Arbitrary identifier value.
  logic clk = 0, rst_n = 0, ra, rk, rh, sa, sk, sd, ps, sp, sr, clr, rd, wr, vld, alarm;
  logic [15:0] rc, rl, sc, sl, addr;
  logic [3:0] los;
  logic [7:0] rm, rdata;
  logic [4:0] gm;
  int n_mismatch = 0, compares = 0;
  always #50 clk = ~clk;
  asr_host host_u(.clk(clk), .vld(vld), .rd(rd), .wr(wr), .addr(addr));
  asr_alarm_status #(.PART_ID(ID)) dut_u(.I_REF_CLK(clk), .I_ARST_N(rst_n), .I_RD_EN(rd),
    .I_WR_EN(wr), .I_ADDR(addr), .I_WDATA(8'hFF), .I_REF_LOCK_COUNT(rc),
    .I_REF_LOCK_LIMIT(rl), .I_REF_LOOP_ACQUIRING(ra), .I_REF_LOOP_LOCKED(rk),
    .I_REF_LOOP_IN_HOLDOVER(rh), .I_INPUT_SIGNAL_LOSS(los), .I_SYNTH_LOCK_COUNT(sc),
    .I_SYNTH_LOCK_LIMIT(sl), .I_SYNTH_LOOP_ACQUIRING(sa), .I_SYNTH_LOOP_LOCKED(sk),
    .I_SYNTH_LOOP_DISABLED(sd), .I_OUTPUT_PHASE_STABLE(ps), .I_SYNC_PULSE(sp),
    .I_SYNC_REQUEST(sr), .I_RECORD_CLEAR(clr), .I_REF_LOOP_MASK(rm),
    .I_GENERAL_MASK(gm), .O_RDATA(rdata), .O_RD_VALID(vld), .O_ALARM(alarm));
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task rdx(input logic [15:0] a, input logic [7:0] e);
    logic v;
    host_u.acc(1'b0, a, v);
    chk(rdata, e);
    chk({7'h00, v}, 8'h01);
  endtask
  task t_id;
    logic v;
    rdx(16'h0078, ID[7:0]);
    rdx(16'h0079, ID[15:8]);
    host_u.acc(1'b1, 16'h007A, v);
    chk({7'h00, v}, 8'h00);
    rdx(16'h007A, ID[23:16]);
  endtask
  task t_ref;
    {ra, rk, rh, los} = 7'b0101010; rl = 16'h0100; rc = 16'h0010;
    rdx(16'h007C, 8'hAA);
    {ra, rk, rh, los} = 7'b1010101; rc = 16'h000F;
    rdx(16'h007C, 8'h55);
  endtask
  task t_gen;
    rk = 1; sk = 1; ps = 1; sl = 16'h0020; sc = 16'h0002;
    rdx(16'h007D, 8'h1F);
    sr = 1; @(negedge clk); sr = 0; sk = 0; sd = 1; ps = 0; sc = 16'h0001;
    rdx(16'h007D, 8'h00);
  endtask
  task t_latch;
    sa = 1; los = 0; rh = 0; ra = 0; @(negedge clk); sa = 0;
    rdx(16'h007E, 8'h7F);
    clr = 1; @(negedge clk); clr = 0;
    rdx(16'h007E, 8'h00);
    rdx(16'h007F, 8'h00);
    rdx(16'h0080, 8'h00);
  endtask
  task t_alarm;
    rm = 8'h01; los = 4'h1;
    rdx(16'h007B, 8'h01);
    chk({7'h00, alarm}, 8'h01);
    rm = 8'h00; gm = 5'h08; sk = 1;
    rdx(16'h007B, 8'h01);
    gm = 5'h00;
    rdx(16'h007B, 8'h00);
  endtask
  task t_reset;
    los = 0; rst_n = 0;
    repeat (2) @(negedge clk);
    chk({6'h00, vld, alarm}, 8'h00);
    chk(rdata, 8'h00);
    rst_n = 1;
    rdx(16'h007D, 8'h1A);
    sp = 1; @(negedge clk); sp = 0;
    rdx(16'h007D, 8'h08);
    los = 4'h2; clr = 1; @(negedge clk); clr = 0; los = 0;
    rdx(16'h007E, 8'h02);
  endtask
  task complete_run;
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {ra, rk, rh, sa, sk, sd, ps, sp, sr, clr} = 0; {rc, rl, sc, sl} = 0;
    los = 0; rm = 0; gm = 0;
    repeat (16) @(negedge clk);
    rst_n = 1;
    t_id; t_ref; t_gen; t_latch; t_alarm; t_reset;
    complete_run;
  end
  initial begin
    #100000; n_mismatch++; complete_run;
  end
endmodule // asr_alarm_status_tb

// ==== sim/asr_host.sv ====
// Host model issuing register accesses over the control port.
`timescale 1ns/100ps
module asr_host (
  input wire logic clk,
  input wire logic vld,
  output logic rd,
  output logic wr,
  output logic [15:0] addr
);
  initial begin
    rd = 0; wr = 0; addr = 16'h0000;
  end
  // Access is taken at one rising edge; data stands after that same edge.
  task acc(input logic w, input logic [15:0] a, output logic v);
    @(negedge clk); rd = !w; wr = w; addr = a;
    @(negedge clk); rd = 0; wr = 0; v = vld;
    @(negedge clk);
  endtask
endmodule // asr_host
